// ---- src/msirq_top.sv ----
// Interrupt request logic: four multi-source groups, priority pick, vector
// read with acknowledge side effect, and two address-match break comparators.
// Assumes CPU-side inputs and peripheral events are on i_clk; only reset is
// asynchronous.
`timescale 1ns/1ps
module msirq_top
  import msirq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [MSIRQ_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [MSIRQ_SRCW-1:0] i_timer_ch0_evt,
  input wire logic [MSIRQ_SRCW-1:0] i_timer_ch1_evt,
  input wire logic [MSIRQ_SRCW-1:0] i_sync_serial_evt,
  input wire logic [MSIRQ_SRCW-1:0] i_twowire_evt,
  input wire logic i_cpu_int_enable_flag,
  input wire logic [MSIRQ_LVLW-1:0] i_processor_priority_level,
  input wire logic i_fetch_valid,
  input wire logic [MSIRQ_PCW-1:0] i_fetch_addr,
  output logic o_int_req,
  output logic [1:0] o_int_num,
  output logic [MSIRQ_LVLW-1:0] o_int_lvl,
  output logic o_ack_pulse,
  output logic [1:0] o_ack_num,
  output logic [MSIRQ_NBRK-1:0] o_addr_break
);
  logic rst_meta_b;
  logic rst_sync_b;
  msirq_bus_t bus_r;
  logic [31:0] rdata_r;
  logic req;
  logic take;
  logic [MSIRQ_SRCW-1:0] evt [MSIRQ_NGRP];
  logic [MSIRQ_SRCW-1:0] stat [MSIRQ_NGRP];
  logic [MSIRQ_SRCW-1:0] en [MSIRQ_NGRP];
  logic [MSIRQ_NGRP-1:0] pend;
  logic [MSIRQ_NGRP-1:0] stat_we;
  logic [MSIRQ_NGRP-1:0] en_we;
  logic [MSIRQ_NGRP-1:0] ctl_we;
  logic [MSIRQ_LVLW-1:0] lvl_r [MSIRQ_NGRP];
  logic [MSIRQ_NBRK-1:0] brk_en_r;
  logic [MSIRQ_PCW-1:0] cmp_r [MSIRQ_NBRK];
  logic [MSIRQ_NBRK-1:0] cmp_we;
  logic sel_vld;
  logic [1:0] sel_num;
  logic [MSIRQ_LVLW-1:0] sel_lvl;
  logic int_req_r;
  logic [1:0] int_num_r;
  logic [MSIRQ_LVLW-1:0] int_lvl_r;
  logic ack_pulse_r;
  logic [1:0] ack_num_r;
  logic vec_rd;
  logic [31:0] rd_mux;

  // Reset released through two flops; asserted at once
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Bus slave: one wait cycle, effect taken on the edge waitrequest is low
  // Fixed wait keeps read data registered; costs one cycle per access
  assign req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && (bus_r != MSIRQ_BUS_ACK);
  assign take = req && (bus_r == MSIRQ_BUS_ACK);

  always_ff @(posedge i_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bus_r <= MSIRQ_BUS_IDLE;
    end else begin
      case (bus_r)
        MSIRQ_BUS_IDLE: begin
          if (req) begin
            bus_r <= MSIRQ_BUS_ACK;
          end
        end
        MSIRQ_BUS_ACK: begin
          bus_r <= MSIRQ_BUS_IDLE;
        end
        default: begin
          bus_r <= MSIRQ_BUS_IDLE;
        end
      endcase
    end
  end

  assign evt[0] = i_timer_ch0_evt;
  assign evt[1] = i_timer_ch1_evt;
  assign evt[2] = i_sync_serial_evt;
  assign evt[3] = i_twowire_evt;

  // Each group has its own status, enable and control registers
  for (genvar g = 0; g < MSIRQ_NGRP; g++) begin : g_grp
    localparam logic [7:0] BASE = MSIRQ_OFF_GRP_BASE + 8'(g) * MSIRQ_GRP_STRIDE;
    assign stat_we[g] = take && i_avs_write && (i_avs_address == BASE + MSIRQ_GRP_STAT);
    assign en_we[g] = take && i_avs_write && (i_avs_address == BASE + MSIRQ_GRP_EN);
    assign ctl_we[g] = take && i_avs_write && (i_avs_address == BASE + MSIRQ_GRP_CTL);

    msirq_merge u_merge (
      .i_clk(i_clk),
      .i_rst_b(rst_sync_b),
      .i_evt(evt[g]),
      .i_stat_we(stat_we[g]),
      .i_en_we(en_we[g]),
      .i_wdata(i_avs_writedata[MSIRQ_SRCW-1:0]),
      .o_stat(stat[g]),
      .o_en(en[g]),
      .o_pend(pend[g])
    );

    // Pending bit in the control write is dropped: it follows status and enable only
    always_ff @(posedge i_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        lvl_r[g] <= MSIRQ_RST_LVL;
      end else if (ctl_we[g]) begin
        lvl_r[g] <= i_avs_writedata[MSIRQ_CTL_LVL_LSB +: MSIRQ_LVLW];
      end
    end
  end

  // Highest level above the processor level; lower index wins a tie
  always_comb begin
    sel_vld = 1'b0;
    sel_num = 2'h0;
    sel_lvl = 3'h0;
    for (int g = 0; g < MSIRQ_NGRP; g++) begin
      if (i_cpu_int_enable_flag && pend[g] && (lvl_r[g] > i_processor_priority_level)
          && (!sel_vld || (lvl_r[g] > sel_lvl))) begin
        sel_vld = 1'b1;
        sel_num = 2'(g);
        sel_lvl = lvl_r[g];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      int_req_r <= 1'b0;
      int_num_r <= 2'h0;
      int_lvl_r <= 3'h0;
    end else begin
      int_req_r <= sel_vld;
      int_num_r <= sel_num;
      int_lvl_r <= sel_lvl;
    end
  end

  // Vector read: acknowledge sequence and stray program reads look the same
  assign vec_rd = take && i_avs_read && (i_avs_address == MSIRQ_OFF_VEC);

  // Acknowledge only reports; multi-source pending stays with its status
  always_ff @(posedge i_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ack_pulse_r <= 1'b0;
      ack_num_r <= 2'h0;
    end else begin
      ack_pulse_r <= vec_rd && int_req_r;
      ack_num_r <= vec_rd ? int_num_r : ack_num_r;
    end
  end

  // Break enables and compare addresses
  assign cmp_we[0] = take && i_avs_write && (i_avs_address == MSIRQ_OFF_CMP0);
  assign cmp_we[1] = take && i_avs_write && (i_avs_address == MSIRQ_OFF_CMP1);

  always_ff @(posedge i_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      brk_en_r <= MSIRQ_RST_BRK_EN;
    end else if (take && i_avs_write && (i_avs_address == MSIRQ_OFF_BRK_EN)) begin
      brk_en_r <= i_avs_writedata[MSIRQ_NBRK-1:0];
    end
  end

  for (genvar b = 0; b < MSIRQ_NBRK; b++) begin : g_brk
    always_ff @(posedge i_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        cmp_r[b] <= MSIRQ_RST_CMP;
      end else if (cmp_we[b]) begin
        cmp_r[b] <= i_avs_writedata[MSIRQ_PCW-1:0];
      end
    end

    msirq_addr_cmp u_cmp (
      .i_clk(i_clk),
      .i_rst_b(rst_sync_b),
      .i_en(brk_en_r[b]),
      .i_cmp(cmp_r[b]),
      .i_fetch_valid(i_fetch_valid),
      .i_fetch_addr(i_fetch_addr),
      .o_hit(o_addr_break[b])
    );
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = MSIRQ_RD_UNMAPPED;
    if (i_avs_address == MSIRQ_OFF_VEC) begin
      rd_mux[MSIRQ_VEC_VALID_BIT] = int_req_r;
      rd_mux[MSIRQ_VEC_NUM_LSB +: 2] = int_num_r;
      rd_mux[MSIRQ_VEC_LVL_LSB +: MSIRQ_LVLW] = int_lvl_r;
    end else if (i_avs_address == MSIRQ_OFF_BRK_EN) begin
      rd_mux[MSIRQ_NBRK-1:0] = brk_en_r;
    end else if (i_avs_address == MSIRQ_OFF_CMP0) begin
      rd_mux[MSIRQ_PCW-1:0] = cmp_r[0];
    end else if (i_avs_address == MSIRQ_OFF_CMP1) begin
      rd_mux[MSIRQ_PCW-1:0] = cmp_r[1];
    end
    for (int g = 0; g < MSIRQ_NGRP; g++) begin
      if (i_avs_address == MSIRQ_OFF_GRP_BASE + 8'(g) * MSIRQ_GRP_STRIDE + MSIRQ_GRP_STAT) begin
        rd_mux[MSIRQ_SRCW-1:0] = stat[g];
      end
      if (i_avs_address == MSIRQ_OFF_GRP_BASE + 8'(g) * MSIRQ_GRP_STRIDE + MSIRQ_GRP_EN) begin
        rd_mux[MSIRQ_SRCW-1:0] = en[g];
      end
      if (i_avs_address == MSIRQ_OFF_GRP_BASE + 8'(g) * MSIRQ_GRP_STRIDE + MSIRQ_GRP_CTL) begin
        rd_mux[MSIRQ_CTL_LVL_LSB +: MSIRQ_LVLW] = lvl_r[g];
        rd_mux[MSIRQ_CTL_PEND_BIT] = pend[g];
      end
    end
  end

  // Loaded in the wait cycle so data stand on the completing edge
  always_ff @(posedge i_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata_r <= MSIRQ_RD_UNMAPPED;
    end else if (i_avs_read && (bus_r == MSIRQ_BUS_IDLE)) begin
      rdata_r <= rd_mux;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_int_req = int_req_r;
  assign o_int_num = int_num_r;
  assign o_int_lvl = int_lvl_r;
  assign o_ack_pulse = ack_pulse_r;
  assign o_ack_num = ack_num_r;

  a_bus_one_wait: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (req && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("bus request waited more than one cycle");
  a_mask_gates_req: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    !i_cpu_int_enable_flag |=> !o_int_req)
    else $error("request raised with mask flag clear");
  a_level_above_ipl: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    o_int_req |-> (o_int_lvl > $past(i_processor_priority_level)))
    else $error("request level not above processor level");
  a_tie_lower_wins: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (i_cpu_int_enable_flag && pend[0] && pend[1] && (lvl_r[0] == lvl_r[1])
     && (lvl_r[0] > i_processor_priority_level)) |=> (o_int_num != 2'h1))
    else $error("tie not resolved to the lower-ranked group");
  a_ack_keeps_pend: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (vec_rd && pend[0] && ((stat[0] & en[0]) != '0) && (i_timer_ch0_evt == '0)
     && !stat_we[0] && !en_we[0]) |=> ##1 pend[0])
    else $error("acknowledge cleared a multi-source pending bit");
  a_ctl_write_no_clear: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (ctl_we[1] && pend[1] && ((stat[1] & en[1]) != '0)) |=> pend[1])
    else $error("control write cleared pending bit");
  a_ack_reports: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (vec_rd && int_req_r) |=> (o_ack_pulse && (o_ack_num == $past(int_num_r))))
    else $error("vector read did not report the acknowledged group");

  // Writes land only on the completing edge, never in the wait cycle
  a_write_on_take: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    ((stat_we != '0) || (en_we != '0) || (ctl_we != '0) || (cmp_we != '0))
     |-> (i_avs_write && !o_avs_waitrequest))
    else $error("register written outside a completed bus write");
  a_ctl_level_write: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    ctl_we[0] |=> (lvl_r[0] == $past(i_avs_writedata[MSIRQ_CTL_LVL_LSB +: MSIRQ_LVLW])))
    else $error("control write did not load the level");
  a_cmp_write: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    cmp_we[1] |=> (cmp_r[1] == $past(i_avs_writedata[MSIRQ_PCW-1:0])))
    else $error("compare write did not load the address");
  a_brk_en_write: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (take && i_avs_write && (i_avs_address == MSIRQ_OFF_BRK_EN))
     |=> (brk_en_r == $past(i_avs_writedata[MSIRQ_NBRK-1:0])))
    else $error("break enable write did not land");

  // Pending readback comes from the merged request, captured in the wait cycle
  a_pend_readback: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (i_avs_read && (bus_r == MSIRQ_BUS_IDLE)
     && (i_avs_address == MSIRQ_OFF_GRP_BASE + MSIRQ_GRP_CTL))
     |=> (o_avs_readdata[MSIRQ_CTL_PEND_BIT] == $past(pend[0])))
    else $error("control read does not show the pending bit");

  // Request and acknowledge side
  a_req_has_pend: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    o_int_req |-> ($past(pend) != '0))
    else $error("request raised with no pending group");
  a_ack_one_cycle: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    o_ack_pulse |=> !o_ack_pulse)
    else $error("acknowledge pulse longer than one cycle");
  a_idle_read_no_ack: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (vec_rd && !int_req_r) |=> !o_ack_pulse)
    else $error("acknowledge reported with no request");
  a_ack_num_hold: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    !vec_rd |=> $stable(o_ack_num))
    else $error("acknowledged group changed without a vector read");

  // Breaks bypass the mask flag and processor level
  a_break_no_mask: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (brk_en_r[0] && i_fetch_valid && (i_fetch_addr == cmp_r[0]) && !i_cpu_int_enable_flag)
     |=> o_addr_break[0])
    else $error("mask flag blocked an address break");
  a_break1_enable: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    !brk_en_r[1] |=> !o_addr_break[1])
    else $error("break source 1 fired while disabled");

  c_vec_read: cover property (@(posedge i_clk) disable iff (!rst_sync_b)
    vec_rd && int_req_r);
  c_break_hit: cover property (@(posedge i_clk) disable iff (!rst_sync_b)
    o_addr_break != '0);
  c_two_pending: cover property (@(posedge i_clk) disable iff (!rst_sync_b)
    $countones(pend) > 1);
  c_masked_pend: cover property (@(posedge i_clk) disable iff (!rst_sync_b)
    !i_cpu_int_enable_flag && (pend != '0));
  c_level_tie: cover property (@(posedge i_clk) disable iff (!rst_sync_b)
    pend[1] && pend[2] && (lvl_r[1] == lvl_r[2]));
endmodule

// ---- src/msirq_pkg.sv ----
// Package: constants and types of the multi-source interrupt request logic.
// Assumes a 32-bit Avalon-MM slave port with byte addresses, word aligned.
package msirq_pkg;
  localparam int MSIRQ_NGRP = 4;
  localparam int MSIRQ_SRCW = 8;
  localparam int MSIRQ_LVLW = 3;
  localparam int MSIRQ_PCW = 20;
  localparam int MSIRQ_NBRK = 2;
  localparam int MSIRQ_AW = 8;
  // Register byte offsets
  localparam logic [7:0] MSIRQ_OFF_VEC = 8'h00;
  localparam logic [7:0] MSIRQ_OFF_BRK_EN = 8'h04;
  localparam logic [7:0] MSIRQ_OFF_CMP0 = 8'h08;
  localparam logic [7:0] MSIRQ_OFF_CMP1 = 8'h0C;
  localparam logic [7:0] MSIRQ_OFF_GRP_BASE = 8'h10;
  localparam logic [7:0] MSIRQ_GRP_STRIDE = 8'h10;
  localparam logic [7:0] MSIRQ_GRP_STAT = 8'h00;
  localparam logic [7:0] MSIRQ_GRP_EN = 8'h04;
  localparam logic [7:0] MSIRQ_GRP_CTL = 8'h08;
  // Field positions
  localparam int MSIRQ_CTL_LVL_LSB = 0;
  localparam int MSIRQ_CTL_PEND_BIT = 3;
  localparam int MSIRQ_VEC_VALID_BIT = 0;
  localparam int MSIRQ_VEC_NUM_LSB = 1;
  localparam int MSIRQ_VEC_LVL_LSB = 4;
  // Reset values
  localparam logic [7:0] MSIRQ_RST_STAT = 8'h00;
  localparam logic [7:0] MSIRQ_RST_EN = 8'h00;
  localparam logic [2:0] MSIRQ_RST_LVL = 3'h0;
  localparam logic [19:0] MSIRQ_RST_CMP = 20'h00000;
  localparam logic [1:0] MSIRQ_RST_BRK_EN = 2'h0;
  localparam logic [31:0] MSIRQ_RD_UNMAPPED = 32'h00000000;
  typedef enum logic [1:0] {
    MSIRQ_BUS_IDLE = 2'b01,
    MSIRQ_BUS_ACK = 2'b10
  } msirq_bus_t;
endpackage

// ---- src/msirq_merge.sv ----
// One multi-source group: status and enable bits and the merged pending bit.
// Assumes single-cycle event pulses and write strobes from the same clock.
`timescale 1ns/1ps
module msirq_merge
  import msirq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [MSIRQ_SRCW-1:0] i_evt,
  input wire logic i_stat_we,
  input wire logic i_en_we,
  input wire logic [MSIRQ_SRCW-1:0] i_wdata,
  output logic [MSIRQ_SRCW-1:0] o_stat,
  output logic [MSIRQ_SRCW-1:0] o_en,
  output logic o_pend
);
  logic [MSIRQ_SRCW-1:0] stat_r;
  logic [MSIRQ_SRCW-1:0] stat_nxt;
  logic [MSIRQ_SRCW-1:0] en_r;
  logic pend_r;

  // Writing 0 clears a bit; a new event in the same cycle wins
  always_comb begin
    stat_nxt = i_stat_we ? (stat_r & i_wdata) : stat_r;
    stat_nxt = stat_nxt | i_evt;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_r <= MSIRQ_RST_STAT;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_r <= MSIRQ_RST_EN;
    end else if (i_en_we) begin
      en_r <= i_wdata;
    end
  end

  // Not latched: recomputed every cycle, so no write or acknowledge holds it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= |(stat_r & en_r);
    end
  end

  assign o_stat = stat_r;
  assign o_en = en_r;
  assign o_pend = pend_r;

  a_pend_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ##1 (o_pend == $past(|(stat_r & en_r))))
    else $error("pending bit does not follow status and enable");
  a_pend_drops: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ((stat_r & en_r) == '0) |=> !o_pend)
    else $error("pending bit held without an enabled status bit");
  a_evt_wins: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_stat_we && (i_evt != '0)) |=> ((stat_r & $past(i_evt)) == $past(i_evt)))
    else $error("status event lost against a clearing write");
endmodule

// ---- src/msirq_addr_cmp.sv ----
// One address-match break comparator with its own enable.
// Assumes the fetch address is valid for one cycle as an instruction starts.
`timescale 1ns/1ps
module msirq_addr_cmp
  import msirq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_en,
  input wire logic [MSIRQ_PCW-1:0] i_cmp,
  input wire logic i_fetch_valid,
  input wire logic [MSIRQ_PCW-1:0] i_fetch_addr,
  output logic o_hit
);
  logic hit_r;

  // No mask flag or priority here: only the enable bit gates it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= i_en && i_fetch_valid && (i_fetch_addr == i_cmp);
    end
  end

  assign o_hit = hit_r;

  a_hit_cause: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_hit |-> $past(i_fetch_valid && (i_fetch_addr == i_cmp)))
    else $error("break hit without a matching fetch");
  a_hit_enable: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_en && i_fetch_valid && (i_fetch_addr == i_cmp)) |=> o_hit)
    else $error("enabled match did not raise a break");
endmodule

// ---- tb/msirq_cpu_model.sv ----
// Partner model: peripheral event sources and the CPU-side core signals.
// Assumes the bench calls one task at a time, all on the rising edge.
`timescale 1ns/1ps
module msirq_cpu_model
  import msirq_pkg::*;
(
  input wire logic i_clk,
  output logic [MSIRQ_NGRP-1:0][MSIRQ_SRCW-1:0] o_evt,
  output logic o_flag,
  output logic [MSIRQ_LVLW-1:0] o_ipl,
  output logic o_fetch_valid,
  output logic [MSIRQ_PCW-1:0] o_fetch_addr
);
  initial begin
    o_evt = '0;
    o_flag = 1'b0;
    o_ipl = '0;
    o_fetch_valid = 1'b0;
    o_fetch_addr = '0;
  end

  // One-cycle factor pulse from peripheral g
  task automatic pulse_evt(input int g, input logic [MSIRQ_SRCW-1:0] bits);
    @(posedge i_clk);
    o_evt[g] <= bits;
    @(posedge i_clk);
    o_evt[g] <= '0;
  endtask

  task automatic fetch(input logic [MSIRQ_PCW-1:0] a);
    @(posedge i_clk);
    o_fetch_valid <= 1'b1;
    o_fetch_addr <= a;
    @(posedge i_clk);
    o_fetch_valid <= 1'b0;
    o_fetch_addr <= ~a; // Stale address differs, so a late match shows up
  endtask

  // Mask flag drops before control changes while requests may arise
  task automatic set_mask(input logic flag, input logic [MSIRQ_LVLW-1:0] processor_priority_level);
    @(posedge i_clk);
    o_flag <= flag;
    o_ipl <= processor_priority_level;
  endtask
endmodule

// ---- tb/msirq_tb.sv ----
// Testbench: register and pin checks of the interrupt request logic.
// Assumes the one-wait-cycle Avalon slave and a registered pending bit.
`timescale 1ns/1ps
module msirq_tb;
  import msirq_pkg::*;
  logic i_clk;
  logic i_rst_b;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [MSIRQ_NGRP-1:0][MSIRQ_SRCW-1:0] evt;
  logic flag;
  logic [2:0] processor_priority_level;
  logic fvalid;
  logic [MSIRQ_PCW-1:0] faddr;
  logic o_int_req;
  logic [1:0] o_int_num;
  logic [2:0] o_int_lvl;
  logic o_ack_pulse;
  logic [1:0] o_ack_num;
  logic [1:0] o_addr_break;
  int failures;
  int checks;
  int ack_cnt;
  logic [1:0] ack_grp;
  int brk0;
  int brk1;
  int acks;

  msirq_cpu_model cpu (.i_clk(i_clk), .o_evt(evt), .o_flag(flag), .o_ipl(processor_priority_level),
    .o_fetch_valid(fvalid), .o_fetch_addr(faddr));

  msirq_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_timer_ch0_evt(evt[0]), .i_timer_ch1_evt(evt[1]), .i_sync_serial_evt(evt[2]),
    .i_twowire_evt(evt[3]), .i_cpu_int_enable_flag(flag),
    .i_processor_priority_level(processor_priority_level), .i_fetch_valid(fvalid), .i_fetch_addr(faddr),
    .o_int_req(o_int_req), .o_int_num(o_int_num), .o_int_lvl(o_int_lvl),
    .o_ack_pulse(o_ack_pulse), .o_ack_num(o_ack_num), .o_addr_break(o_addr_break));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Pulses are one cycle wide, so counting them avoids guessing their cycle
  always @(posedge i_clk) begin
    if (o_ack_pulse === 1'b1) begin
      ack_cnt++;
      ack_grp = o_ack_num;
    end
    if (o_addr_break[0] === 1'b1) brk0++;
    if (o_addr_break[1] === 1'b1) brk1++;
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= we;
    avs_read <= ~we;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    rd = o_avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) failures++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h00000000, d);
    checks++;
    if (d !== exp) begin
      failures++;
      $display("CHECK FAILED %0t: reg %h got %h exp %h", $time, a, d, exp);
    end
  endtask

  task automatic chk_pin(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] ga(input int g, input logic [7:0] off);
    return MSIRQ_OFF_GRP_BASE + MSIRQ_GRP_STRIDE * 8'(g) + off;
  endfunction

  task automatic settle;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic done(input string t);
    $display("test %s done, checks %0d failures %0d", t, checks, failures);
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    stop_test;
  end

  initial begin
    i_rst_b = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int g = 0; g < MSIRQ_NGRP; g++) begin
      chk_reg(ga(g, MSIRQ_GRP_STAT), 32'h00000000);
      chk_reg(ga(g, MSIRQ_GRP_EN), 32'h00000000);
      chk_reg(ga(g, MSIRQ_GRP_CTL), 32'h00000000);
    end
    chk_reg(MSIRQ_OFF_BRK_EN, 32'h00000000);
    chk_reg(MSIRQ_OFF_CMP1, 32'h00000000);
    chk_reg(8'h50, 32'h00000000);
    chk_reg(MSIRQ_OFF_VEC, 32'h00000000);
    chk_pin("idle ack", 32'(ack_cnt), 32'd0);
    done("reset");
    cpu.set_mask(1'b1, 3'h0);
    for (int g = 0; g < MSIRQ_NGRP; g++) begin
      wr(ga(g, MSIRQ_GRP_EN), 32'h00000005);
      wr(ga(g, MSIRQ_GRP_CTL), 32'h00000003);
      cpu.pulse_evt(g, 8'h02);
      settle();
      chk_reg(ga(g, MSIRQ_GRP_STAT), 32'h00000002);
      chk_reg(ga(g, MSIRQ_GRP_CTL), 32'h00000003);
      cpu.pulse_evt(g, 8'h04);
      settle();
      chk_reg(ga(g, MSIRQ_GRP_CTL), 32'h0000000B);
      chk_pin("req", 32'(o_int_req), 32'd1);
      chk_pin("num", 32'(o_int_num), 32'(g));
      chk_pin("lvl", 32'(o_int_lvl), 32'd3);
      cpu.pulse_evt(g, 8'h01);
      settle();
      chk_reg(ga(g, MSIRQ_GRP_CTL), 32'h0000000B);
      wr(ga(g, MSIRQ_GRP_CTL), 32'h00000003);
      chk_reg(ga(g, MSIRQ_GRP_CTL), 32'h0000000B);
      acks = ack_cnt;
      chk_reg(MSIRQ_OFF_VEC, 32'h00000031 | (32'(g) << MSIRQ_VEC_NUM_LSB));
      settle();
      chk_pin("ack count", 32'(ack_cnt), 32'(acks + 1));
      chk_pin("ack num", 32'(ack_grp), 32'(g));
      chk_reg(ga(g, MSIRQ_GRP_STAT), 32'h00000007);
      chk_reg(ga(g, MSIRQ_GRP_CTL), 32'h0000000B);
      wr(ga(g, MSIRQ_GRP_STAT), 32'h000000FB);
      chk_reg(ga(g, MSIRQ_GRP_CTL), 32'h0000000B);
      wr(ga(g, MSIRQ_GRP_EN), 32'h00000004);
      chk_reg(ga(g, MSIRQ_GRP_CTL), 32'h00000003);
      chk_reg(ga(g, MSIRQ_GRP_STAT), 32'h00000003);
      wr(ga(g, MSIRQ_GRP_STAT), 32'h00000000);
      wr(ga(g, MSIRQ_GRP_EN), 32'h00000000);
      chk_reg(ga(g, MSIRQ_GRP_CTL), 32'h00000003);
      settle();
      chk_pin("req off", 32'(o_int_req), 32'd0);
    end
    done("groups");
    cpu.set_mask(1'b0, 3'h0);
    for (int g = 0; g < 3; g++) begin
      wr(ga(g, MSIRQ_GRP_EN), 32'h00000001);
      wr(ga(g, MSIRQ_GRP_CTL), (g == 0) ? 32'h00000002 : 32'h00000005);
      cpu.pulse_evt(g, 8'h01);
    end
    settle();
    chk_pin("masked", 32'(o_int_req), 32'd0);
    cpu.set_mask(1'b1, 3'h0);
    settle();
    chk_pin("rank num", 32'(o_int_num), 32'd1);
    chk_pin("rank lvl", 32'(o_int_lvl), 32'd5);
    cpu.set_mask(1'b1, 3'h5);
    settle();
    chk_pin("ipl high", 32'(o_int_req), 32'd0);
    cpu.set_mask(1'b1, 3'h1);
    settle();
    chk_pin("ipl low", 32'(o_int_req), 32'd1);
    done("gating");
    cpu.set_mask(1'b0, 3'h7);
    wr(MSIRQ_OFF_CMP0, 32'h00012345);
    wr(MSIRQ_OFF_CMP1, 32'h000ABCDE);
    chk_reg(MSIRQ_OFF_CMP0, 32'h00012345);
    wr(MSIRQ_OFF_BRK_EN, 32'h00000001);
    cpu.fetch(20'h12345);
    cpu.fetch(20'hABCDE);
    settle();
    chk_pin("brk0", 32'(brk0), 32'd1);
    chk_pin("brk1 off", 32'(brk1), 32'd0);
    wr(MSIRQ_OFF_BRK_EN, 32'h00000002);
    cpu.fetch(20'hABCDE);
    cpu.fetch(20'h12345);
    settle();
    chk_pin("brk1", 32'(brk1), 32'd1);
    chk_pin("brk0 off", 32'(brk0), 32'd1);
    done("break");
    stop_test;
  end
endmodule
